// *** src/keypad_light_ctrl.v ***
// frame interpreter and light state for symbol and halo leds
// What this block does
// - object 0x6B subindex 0..5 writes the symbol pattern of buttons 1..6
// - pattern 0 steady, 1 slow flash, 2 fast flash, 3 pulsate
// - only slow and fast flash have adjustable on time and period
// - object 0x29 sets slow flash on time in ms
// - object 0x2A sets slow flash repeat period in ms
// - object 0x2B sets fast flash on time in ms
// - object 0x2C sets fast flash repeat period in ms
// - the four flash timings start at defaults and accept overwrites
// - global symbol brightness scales every symbol pattern, 0 off to 250 full
// - global brightness hits every symbol led at once
// - config message 0x10 carries global symbol brightness in byte 2
// - object 0x67 sets global symbol brightness like the message
// - each halo ring has four independently lit leds
// - all values return to defaults at reset, except the stored bank, which has no reset; stored values come back only on restore
// - halo led lights only when both mask bit and button enable set
// - config message 0x16 loads halo masks, bytes 1..6 for buttons
// - mask bits: 3 top-left, 0 top-right, 2 bottom-left, 1 bottom-right
// - config message 0x10 carries halo enable bits in byte 3
// - enable bit n-1 stands for button n, six bits
// - object 0x68 subindex 0..5 writes halo enable of buttons 1..6
// - object 0x68 gives the same halo state as the message
`timescale 1ns/1ns
`default_nettype none
`include "keypad_light_regs.vh"
module keypad_light_ctrl #(
    parameter BUTTONS = 6,
    parameter MS_CYCLES = `MS_CYCLES
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // received can frame
    input wire rx_valid_i,
    input wire rx_ext_i,
    input wire [28:0] rx_id_i,
    input wire [3:0] rx_dlc_i,
    input wire [63:0] rx_data_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // led drive
    output reg [BUTTONS-1:0] symbol_on_o,
    output reg [8*BUTTONS-1:0] symbol_level_o,
    output reg [4*BUTTONS-1:0] halo_on_o
);
    reg [7:0] slow_on_time;
    reg [7:0] slow_blink_repeat_interval;
    reg [7:0] fast_on_time;
    reg [7:0] fast_blink_repeat_interval;
    reg [7:0] sym_global;
    reg [2*BUTTONS-1:0] sym_pattern;
    reg [4*BUTTONS-1:0] halo_mask;
    reg [BUTTONS-1:0] halo_en;
    reg [7:0] taken_count;
    reg [7:0] ignored_count;
    // stored bank stands in for non-volatile memory, so it has no reset
    reg [31:0] nv_bank [0:4];
    reg [7:0] ramp;
    reg ramp_down;
    reg [7:0] ramp_div;

    wire tick;
    wire slow_lit;
    wire fast_lit;

    wire [7:0] byte0 = rx_data_i[7:0];
    wire [7:0] byte1 = rx_data_i[15:8];
    wire [7:0] byte2 = rx_data_i[23:16];
    wire [7:0] byte3 = rx_data_i[31:24];

    // only 8-byte extended frames with the config id are ours
    wire frame_ok = rx_valid_i & rx_ext_i & (rx_id_i == `CAN_CFG_ID) &
        (rx_dlc_i == `CAN_DLC);
    wire is_obj = frame_ok & (byte0 == `FN_OBJ_WRITE);
    wire is_main = frame_ok & (byte0 == `FN_MAIN_CFG);
    wire is_mask = frame_ok & (byte0 == `FN_HALO_MASK);
    wire sub_ok = (byte2 < BUTTONS);
    wire obj_known = (byte1 == `OBJ_SLOW_ON) |
        (byte1 == `OBJ_SLOW_REPEAT) | (byte1 == `OBJ_FAST_ON) |
        (byte1 == `OBJ_FAST_REPEAT) | (byte1 == `OBJ_SYM_GLOBAL) |
        ((byte1 == `OBJ_HALO_EN) & sub_ok) |
        ((byte1 == `OBJ_SYM_PATTERN) & sub_ok & (byte3 <= `PAT_MAX));
    wire handled = is_main | is_mask | (is_obj & obj_known);

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    wire ctrl_wr = wb_wr & (wb_adr_i == `REG_CTRL) & wb_sel_i[0];
    wire do_commit = ctrl_wr & wb_dat_i[`CTRL_COMMIT];
    wire do_restore = ctrl_wr & wb_dat_i[`CTRL_RESTORE];

    wire [31:0] timing_word = {fast_blink_repeat_interval, fast_on_time,
        slow_blink_repeat_interval, slow_on_time};

    // merge write data into old value under byte enables
    function [31:0] merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] sel;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                merge[i*8 +: 8] = sel[i] ? new_val[i*8 +: 8]
                    : old_val[i*8 +: 8];
        end
    endfunction

    // brightness above full scale is held at full scale
    function [7:0] clamp;
        input [7:0] v;
        begin
            clamp = (v > `BRIGHT_FULL) ? `BRIGHT_FULL : v;
        end
    endfunction

    // merged words are cut back to the stored width on purpose
    wire [31:0] pattern_merged = merge({{(32-2*BUTTONS){1'b0}},
        sym_pattern}, wb_dat_i, wb_sel_i);
    wire [31:0] mask_merged = merge({{(32-4*BUTTONS){1'b0}},
        halo_mask}, wb_dat_i, wb_sel_i);

    ms_tick #(
        .CYCLES(MS_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // only the two flash modes get timers of their own
    flash_timer #(
        .W(8)
    ) u_slow (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .on_ms_i(slow_on_time),
        .repeat_ms_i(slow_blink_repeat_interval),
        .lit_o(slow_lit)
    );

    flash_timer #(
        .W(8)
    ) u_fast (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .on_ms_i(fast_on_time),
        .repeat_ms_i(fast_blink_repeat_interval),
        .lit_o(fast_lit)
    );

    // configuration state; frame fields are assigned after bus writes
    // so a frame in the same cycle wins on the fields it touches, except against a restore, which drops it
    integer b;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slow_on_time <= `DEF_SLOW_ON;
            slow_blink_repeat_interval <= `DEF_SLOW_REPEAT;
            fast_on_time <= `DEF_FAST_ON;
            fast_blink_repeat_interval <= `DEF_FAST_REPEAT;
            sym_global <= `DEF_GLOBAL;
            sym_pattern <= {(2*BUTTONS){1'b0}};
            halo_mask <= {(4*BUTTONS){1'b0}};
            halo_en <= {BUTTONS{1'b0}};
        end
        else if (do_restore)
        begin
            {fast_blink_repeat_interval, fast_on_time,
                slow_blink_repeat_interval, slow_on_time} <= nv_bank[0];
            sym_global <= nv_bank[1][7:0];
            sym_pattern <= nv_bank[2][2*BUTTONS-1:0];
            halo_mask <= nv_bank[3][4*BUTTONS-1:0];
            halo_en <= nv_bank[4][BUTTONS-1:0];
        end
        else
        begin
            if (wb_wr)
            begin
                case (wb_adr_i)
                    `REG_TIMING:
                    begin
                        {fast_blink_repeat_interval, fast_on_time,
                            slow_blink_repeat_interval, slow_on_time} <=
                            merge(timing_word, wb_dat_i, wb_sel_i);
                    end
                    `REG_BRIGHT:
                    begin
                        if (wb_sel_i[0])
                            sym_global <= clamp(wb_dat_i[7:0]);
                    end
                    `REG_PATTERN:
                    begin
                        sym_pattern <= pattern_merged[2*BUTTONS-1:0];
                    end
                    `REG_HALO_MASK:
                    begin
                        halo_mask <= mask_merged[4*BUTTONS-1:0];
                    end
                    `REG_HALO_EN:
                    begin
                        if (wb_sel_i[0])
                            halo_en <= wb_dat_i[BUTTONS-1:0];
                    end
                    default:
                    begin
                    end
                endcase
            end
            if (is_main)
            begin
                sym_global <= clamp(byte2);
                halo_en <= byte3[BUTTONS-1:0];
            end
            if (is_mask)
            begin
                for (b = 0; b < BUTTONS; b = b + 1)
                    halo_mask[4*b +: 4] <= rx_data_i[8*(b+1) +: 4];
            end
            if (is_obj)
            begin
                case (byte1)
                    `OBJ_SLOW_ON: slow_on_time <= byte3;
                    `OBJ_SLOW_REPEAT:
                        slow_blink_repeat_interval <= byte3;
                    `OBJ_FAST_ON: fast_on_time <= byte3;
                    `OBJ_FAST_REPEAT:
                        fast_blink_repeat_interval <= byte3;
                    `OBJ_SYM_GLOBAL: sym_global <= clamp(byte3);
                    `OBJ_HALO_EN:
                    begin
                        for (b = 0; b < BUTTONS; b = b + 1)
                            if (byte2 == b)
                                halo_en[b] <= (byte3 != 8'h00);
                    end
                    `OBJ_SYM_PATTERN:
                    begin
                        for (b = 0; b < BUTTONS; b = b + 1)
                            if ((byte2 == b) && (byte3 <= `PAT_MAX))
                                sym_pattern[2*b +: 2] <= byte3[1:0];
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // snapshot into the stored bank on commit
    always @(posedge clk_i)
    begin
        if (do_commit)
        begin
            nv_bank[0] <= timing_word;
            nv_bank[1] <= {24'h000000, sym_global};
            nv_bank[2] <= {{(32-2*BUTTONS){1'b0}}, sym_pattern};
            nv_bank[3] <= {{(32-4*BUTTONS){1'b0}}, halo_mask};
            nv_bank[4] <= {{(32-BUTTONS){1'b0}}, halo_en};
        end
    end

    // frame statistics for software
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            taken_count <= 8'h00;
            ignored_count <= 8'h00;
        end
        else if (frame_ok)
        begin
            if (handled)
                taken_count <= taken_count + 8'h01;
            else
                ignored_count <= ignored_count + 8'h01;
        end
    end

    // fixed-rate triangle for the pulsate pattern
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ramp <= 8'h00;
            ramp_down <= 1'b0;
            ramp_div <= 8'h00;
        end
        else if (tick)
        begin
            if (ramp_div + 8'h01 >= `PULSE_STEP_MS)
            begin
                ramp_div <= 8'h00;
                if (ramp_down)
                begin
                    if (ramp == 8'h00)
                        ramp_down <= 1'b0;
                    else
                        ramp <= ramp - 8'h01;
                end
                else
                begin
                    if (ramp >= `BRIGHT_FULL)
                        ramp_down <= 1'b1;
                    else
                        ramp <= ramp + 8'h01;
                end
            end
            else
                ramp_div <= ramp_div + 8'h01;
        end
    end

    // led outputs; the global factor is shared by every button
    reg [15:0] pulse_prod;
    reg [7:0] pulse_level;
    always @*
    begin
        pulse_prod = sym_global * ramp;
        pulse_level = pulse_prod[15:8];
    end

    integer k;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            symbol_on_o <= {BUTTONS{1'b0}};
            symbol_level_o <= {(8*BUTTONS){1'b0}};
            halo_on_o <= {(4*BUTTONS){1'b0}};
        end
        else
        begin
            for (k = 0; k < BUTTONS; k = k + 1)
            begin
                halo_on_o[4*k +: 4] <= halo_mask[4*k +: 4] &
                    {4{halo_en[k]}};
                case (sym_pattern[2*k +: 2])
                    `PAT_STEADY:
                    begin
                        symbol_on_o[k] <= (sym_global != 8'h00);
                        symbol_level_o[8*k +: 8] <= sym_global;
                    end
                    `PAT_SLOW:
                    begin
                        symbol_on_o[k] <= slow_lit & (sym_global != 8'h00);
                        symbol_level_o[8*k +: 8] <= slow_lit ? sym_global
                            : 8'h00;
                    end
                    `PAT_FAST:
                    begin
                        symbol_on_o[k] <= fast_lit & (sym_global != 8'h00);
                        symbol_level_o[8*k +: 8] <= fast_lit ? sym_global
                            : 8'h00;
                    end
                    default:
                    begin
                        symbol_on_o[k] <= (pulse_level != 8'h00);
                        symbol_level_o[8*k +: 8] <= pulse_level;
                    end
                endcase
            end
        end
    end

    // wishbone: one answer the cycle after the request, registered, dropped next cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req)
            begin
                case (wb_adr_i)
                    `REG_TIMING: wb_dat_o <= timing_word;
                    `REG_BRIGHT: wb_dat_o <= {24'h000000, sym_global};
                    `REG_PATTERN:
                        wb_dat_o <= {{(32-2*BUTTONS){1'b0}}, sym_pattern};
                    `REG_HALO_MASK:
                        wb_dat_o <= {{(32-4*BUTTONS){1'b0}}, halo_mask};
                    `REG_HALO_EN:
                        wb_dat_o <= {{(32-BUTTONS){1'b0}}, halo_en};
                    `REG_STATUS:
                        wb_dat_o <= {14'h0000, fast_lit, slow_lit,
                            ignored_count, taken_count};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // keypad_light_ctrl
`default_nettype wire

// *** src/keypad_light_regs.vh ***
// register offsets, frame codes, defaults and timing constants
`ifndef KEYPAD_LIGHT_REGS_VH
`define KEYPAD_LIGHT_REGS_VH

// timing
`define CLK_PERIOD_NS 50
`define MS_IN_NS 1000000
`define MS_CYCLES (`MS_IN_NS / `CLK_PERIOD_NS)
`define PULSE_STEP_MS 8'h04

// frame layout
`define CAN_CFG_ID 29'h18EFFF00
`define CAN_DLC 4'h8
`define FN_OBJ_WRITE 8'h04
`define FN_MAIN_CFG 8'h10
`define FN_HALO_MASK 8'h16

// object numbers
`define OBJ_SLOW_ON 8'h29
`define OBJ_SLOW_REPEAT 8'h2A
`define OBJ_FAST_ON 8'h2B
`define OBJ_FAST_REPEAT 8'h2C
`define OBJ_SYM_GLOBAL 8'h67
`define OBJ_HALO_EN 8'h68
`define OBJ_SYM_PATTERN 8'h6B

// pattern codes
`define PAT_STEADY 2'h0
`define PAT_SLOW 2'h1
`define PAT_FAST 2'h2
`define PAT_PULSE 2'h3
`define PAT_MAX 8'h03

// brightness
`define BRIGHT_FULL 8'hFA

// defaults
`define DEF_SLOW_ON 8'h64
`define DEF_SLOW_REPEAT 8'hC8
`define DEF_FAST_ON 8'h14
`define DEF_FAST_REPEAT 8'h32
`define DEF_GLOBAL 8'hFA

// register byte offsets
`define REG_CTRL 6'h00
`define REG_TIMING 6'h04
`define REG_BRIGHT 6'h08
`define REG_PATTERN 6'h0C
`define REG_HALO_MASK 6'h10
`define REG_HALO_EN 6'h14
`define REG_STATUS 6'h18

// control bits
`define CTRL_COMMIT 0
`define CTRL_RESTORE 1

`endif

// *** src/ms_tick.v ***
// one-cycle tick every millisecond
`timescale 1ns/1ns
`default_nettype none
module ms_tick #(
    parameter CYCLES = 20000
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // tick
    output reg tick_o
);
    reg [31:0] count;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count <= 32'h0;
            tick_o <= 1'b0;
        end
        else if (count == CYCLES - 1)
        begin
            count <= 32'h0;
            tick_o <= 1'b1;
        end
        else
        begin
            count <= count + 32'h1;
            tick_o <= 1'b0;
        end
    end
endmodule // ms_tick
`default_nettype wire

// *** src/flash_timer.v ***
// on/off flash phase counted in millisecond ticks
`timescale 1ns/1ns
`default_nettype none
module flash_timer #(
    parameter W = 8
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // timing
    input wire tick_i,
    input wire [W-1:0] on_ms_i,
    input wire [W-1:0] repeat_ms_i,
    // phase
    output reg lit_o
);
    reg [W-1:0] elapsed;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            elapsed <= {W{1'b0}};
            lit_o <= 1'b0;
        end
        else
        begin
            // a zero or one period simply restarts every tick
            if (tick_i)
            begin
                if (elapsed + {{(W-1){1'b0}}, 1'b1} >= repeat_ms_i)
                    elapsed <= {W{1'b0}};
                else
                    elapsed <= elapsed + {{(W-1){1'b0}}, 1'b1};
            end
            lit_o <= (elapsed < on_ms_i);
        end
    end
endmodule // flash_timer
`default_nettype wire

// *** sim/keypad_light_ctrl_props.sv ***
// concurrent checks on the controller ports
`timescale 1ns/1ns
`default_nettype none
`include "keypad_light_regs.vh"
module keypad_light_props #(parameter BUTTONS = 6) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // frame side
    input wire logic rx_valid_i,
    input wire logic rx_ext_i,
    input wire logic [28:0] rx_id_i,
    input wire logic [3:0] rx_dlc_i,
    input wire logic [63:0] rx_data_i,
    // bus side
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    // led drive
    input wire logic [BUTTONS-1:0] symbol_on_o,
    input wire logic [8*BUTTONS-1:0] symbol_level_o,
    input wire logic [4*BUTTONS-1:0] halo_on_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    wire logic cfg_ok = rx_valid_i && rx_ext_i && rx_id_i == `CAN_CFG_ID
        && rx_dlc_i == `CAN_DLC;
    wire logic wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic [7:0] fn = rx_data_i[7:0];

    function automatic logic lv_le(input logic [8*BUTTONS-1:0] l,
        input logic [7:0] g);
        lv_le = 1'b1;
        for (int k = 0; k < BUTTONS; k++)
            lv_le &= (l[8*k +: 8] <= g);
    endfunction

    property p_ack_next;
        wr_take |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_reset_clear;
        $fell(rst_i) |-> halo_on_o == '0 && symbol_on_o == '0 && !wb_ack_o;
    endproperty
    property p_reset_dflt;
        $fell(rst_i) |=> symbol_on_o == '1
            && symbol_level_o == {BUTTONS{8'hFA}};
    endproperty
    property p_sym_dark;
        cfg_ok && fn == `FN_MAIN_CFG && rx_data_i[23:16] == 8'h00
            |-> ##2 symbol_on_o == '0 && symbol_level_o == '0;
    endproperty
    property p_glob_cap;
        cfg_ok && rx_data_i[15:0] == {`OBJ_SYM_GLOBAL, `FN_OBJ_WRITE}
            |-> ##2 lv_le(symbol_level_o, $past(rx_data_i[31:24], 2));
    endproperty
    property p_halo_off;
        cfg_ok && fn == `FN_MAIN_CFG && !rx_data_i[24]
            |-> ##2 halo_on_o[3:0] == 4'h0;
    endproperty
    property p_halo_obj;
        cfg_ok && rx_data_i[31:0] == {16'h0000, `OBJ_HALO_EN, `FN_OBJ_WRITE}
            |-> ##2 halo_on_o[3:0] == 4'h0;
    endproperty
    property p_mask_sub;
        cfg_ok && fn == `FN_HALO_MASK
            |-> ##2 (halo_on_o[3:0] & ~$past(rx_data_i[11:8], 2)) == 4'h0;
    endproperty
    property p_halo_cause;
        $changed(halo_on_o) |-> $past(cfg_ok, 2) || $past(wr_take, 2);
    endproperty

    a_ack_next: assert property (p_ack_next) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
    a_reset_clear: assert property (p_reset_clear) else $error("rst");
    a_reset_dflt: assert property (p_reset_dflt) else $error("dflt");
    a_sym_dark: assert property (p_sym_dark) else $error("dark");
    a_glob_cap: assert property (p_glob_cap) else $error("glob");
    a_halo_off: assert property (p_halo_off) else $error("en");
    a_halo_obj: assert property (p_halo_obj) else $error("obj");
    a_mask_sub: assert property (p_mask_sub) else $error("mask");
    a_halo_cause: assert property (p_halo_cause) else $error("hc");

    c_mask: cover property (cfg_ok && fn == `FN_HALO_MASK);
    c_halo: cover property (halo_on_o != '0);
    c_write: cover property (wr_take && wb_we_i);
endmodule // keypad_light_props

bind keypad_light_ctrl keypad_light_props #(.BUTTONS(BUTTONS)) u_props (
    .clk_i(clk_i), .rst_i(rst_i),
    .rx_valid_i(rx_valid_i), .rx_ext_i(rx_ext_i), .rx_id_i(rx_id_i),
    .rx_dlc_i(rx_dlc_i), .rx_data_i(rx_data_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .symbol_on_o(symbol_on_o),
    .symbol_level_o(symbol_level_o), .halo_on_o(halo_on_o)
);
`default_nettype wire

// *** sim/can_host_model.sv ***
// host model handing received frames to the controller
`timescale 1ns/1ns
`default_nettype none
`include "keypad_light_regs.vh"
module can_host_model (
    // clock
    input wire logic clk_i,
    // frame out
    output logic rx_valid_o,
    output logic rx_ext_o,
    output logic [28:0] rx_id_o,
    output logic [3:0] rx_dlc_o,
    output logic [63:0] rx_data_o
);
    initial {rx_valid_o, rx_ext_o, rx_id_o, rx_dlc_o, rx_data_o} = '0;

    task automatic put(input logic ext, input logic [28:0] id,
        input logic [3:0] dlc, input logic [63:0] d);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_ext_o <= ext;
        rx_id_o <= id;
        rx_dlc_o <= dlc;
        rx_data_o <= d;
    endtask
    // lines are inverted between frames so stale fields never look valid
    task automatic idle;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_id_o <= ~rx_id_o;
        rx_data_o <= ~rx_data_o;
    endtask
    task automatic cfg(input logic [63:0] d);
        put(1'b1, `CAN_CFG_ID, `CAN_DLC, d);
        idle;
    endtask
    task automatic obj(input logic [7:0] o, input logic [7:0] s,
        input logic [7:0] v);
        cfg({32'h0, v, s, o, `FN_OBJ_WRITE});
    endtask
endmodule // can_host_model
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the keypad light controller
`timescale 1ns/1ns
`default_nettype none
`include "keypad_light_regs.vh"
module tb_top;
    localparam int MSC = 4;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, st;
    logic wb_ack_o, rx_valid_i, rx_ext_i;
    logic [28:0] rx_id_i;
    logic [3:0] rx_dlc_i;
    logic [63:0] rx_data_i;
    logic [5:0] symbol_on_o;
    logic [47:0] symbol_level_o;
    logic [23:0] halo_on_o;
    logic [7:0] lo = 8'hFF, hi = 8'h00;
    int err_count = 0, n_tests = 0, c0, c1, c3;

    initial forever #25 clk_i = ~clk_i;

    can_host_model host (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
        .rx_ext_o(rx_ext_i), .rx_id_o(rx_id_i), .rx_dlc_o(rx_dlc_i),
        .rx_data_o(rx_data_i));

    keypad_light_ctrl #(.BUTTONS(6), .MS_CYCLES(MSC)) DUT (
        .clk_i(clk_i), .rst_i(rst_i),
        .rx_valid_i(rx_valid_i), .rx_ext_i(rx_ext_i), .rx_id_i(rx_id_i),
        .rx_dlc_i(rx_dlc_i), .rx_data_i(rx_data_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .symbol_on_o(symbol_on_o), .symbol_level_o(symbol_level_o),
        .halo_on_o(halo_on_o));

    task automatic check(input string what, input logic [63:0] seen,
        input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // answer time is never assumed
    task automatic bus(input logic we, input logic [5:0] a,
        input logic [3:0] s, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && ++n < 20);
        check("ack", n < 20, 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input string what,
        input logic [31:0] exp);
        bus(1'b0, a, 4'hF, 32'h0);
        check(what, q, exp);
    endtask

    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        settle;
        check("sym_on", symbol_on_o, 6'h3F);
        check("level", symbol_level_o, {6{8'hFA}});
        check("halo", halo_on_o, 24'h0);
        rd(`REG_TIMING, "timing", {`DEF_FAST_REPEAT, `DEF_FAST_ON,
            `DEF_SLOW_REPEAT, `DEF_SLOW_ON});
        rd(`REG_CTRL, "ctrl", 32'h0);
        bus(1'b1, 6'h1C, 4'hF, 32'hFFFFFFFF);
        rd(6'h1C, "unmapped", 32'h0);
        bus(1'b1, `REG_TIMING, 4'h2, 32'h00007700);
        rd(`REG_TIMING, "sel", {`DEF_FAST_REPEAT, `DEF_FAST_ON, 8'h77,
            `DEF_SLOW_ON});
        // timing objects arrive back to back
        st = 32'h04010A05;
        for (int i = 0; i < 4; i++)
            host.put(1'b1, `CAN_CFG_ID, `CAN_DLC, {32'h0, st[8*i +: 8],
                8'h00, 8'(`OBJ_SLOW_ON + i), `FN_OBJ_WRITE});
        host.idle;
        rd(`REG_TIMING, "timing", st);
        for (int i = 0; i < 4; i++)
            host.obj(`OBJ_SYM_PATTERN, 8'(i), 8'((i + 1) % 4));
        rd(`REG_PATTERN, "pattern", 32'h39);
        // whole flash periods
        repeat (40 * MSC)
        begin
            @(posedge clk_i);
            c0 += symbol_on_o[0];
            c1 += symbol_on_o[1];
            c3 += symbol_on_o[3];
            if (symbol_level_o[23:16] < lo) lo = symbol_level_o[23:16];
            if (symbol_level_o[23:16] > hi) hi = symbol_level_o[23:16];
        end
        check("slow", c0 >= 19 * MSC && c0 <= 21 * MSC, 1'b1);
        check("fast", c1 >= 9 * MSC && c1 <= 11 * MSC, 1'b1);
        check("steady", c3, 40 * MSC);
        check("pulse", lo < hi && hi <= 8'hFA, 1'b1);
        bus(1'b0, `REG_STATUS, 4'hF, 32'h0);
        st = q;
        host.obj(`OBJ_SYM_PATTERN, 8'h00, 8'h04);
        host.obj(`OBJ_HALO_EN, 8'h06, 8'h01);
        host.obj(8'h55, 8'h00, 8'h01);
        host.put(1'b0, `CAN_CFG_ID, `CAN_DLC, 64'h10);
        host.put(1'b1, `CAN_CFG_ID, 4'h4, 64'h10);
        host.idle;
        bus(1'b0, `REG_STATUS, 4'hF, 32'h0);
        check("ignored", q[15:0], st[15:0] + 16'h0300);
        rd(`REG_PATTERN, "pattern", 32'h39);
        rd(`REG_BRIGHT, "bright", 32'hFA);
        rd(`REG_HALO_EN, "halo_en", 32'h0);
        for (int i = 0; i < 6; i++)
            host.obj(`OBJ_SYM_PATTERN, 8'(i), 8'h00);
        host.cfg({40'h0, 8'h32, 8'h00, `FN_MAIN_CFG});
        settle;
        check("level", symbol_level_o, {6{8'h32}});
        host.obj(`OBJ_SYM_GLOBAL, 8'h00, 8'h7D);
        settle;
        check("level", symbol_level_o, {6{8'h7D}});
        host.cfg({40'h0, 8'h00, 8'h00, `FN_MAIN_CFG});
        settle;
        check("sym_on", symbol_on_o, 6'h00);
        host.obj(`OBJ_SYM_GLOBAL, 8'h00, 8'hFF);
        rd(`REG_BRIGHT, "clamp", 32'hFA);
        // masks first, then enables
        host.cfg({8'h0, 8'h3A, 8'h0F, 8'h02, 8'h04, 8'h01, 8'h18,
            `FN_HALO_MASK});
        settle;
        check("halo", halo_on_o, 24'h0);
        rd(`REG_HALO_MASK, "mask", 32'hAF2418);
        host.cfg({32'h0, 8'h05, 8'hFA, 8'h00, `FN_MAIN_CFG});
        settle;
        check("halo", halo_on_o, 24'h000408);
        host.obj(`OBJ_HALO_EN, 8'h05, 8'h01);
        host.obj(`OBJ_HALO_EN, 8'h00, 8'h00);
        settle;
        check("halo", halo_on_o, 24'hA00400);
        rd(`REG_HALO_EN, "halo_en", 32'h24);
        host.cfg({32'h0, 8'h00, 8'hFA, 8'h00, `FN_MAIN_CFG});
        host.cfg({32'h0, 8'h24, 8'hFA, 8'h00, `FN_MAIN_CFG});
        settle;
        check("halo", halo_on_o, 24'hA00400);
        bus(1'b1, `REG_BRIGHT, 4'h1, 32'h40);
        bus(1'b1, `REG_CTRL, 4'h1, 32'h1);
        bus(1'b1, `REG_BRIGHT, 4'h1, 32'h11);
        bus(1'b1, `REG_CTRL, 4'h1, 32'h2);
        rd(`REG_BRIGHT, "restore", 32'h40);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`REG_BRIGHT, "bright", 32'hFA);
        rd(`REG_HALO_EN, "halo_en", 32'h0);
        check("halo", halo_on_o, 24'h0);
        tally_and_finish;
    end

    // whole run needs a few hundred cycles
    initial
    begin
        #2000000;
        err_count++;
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
